// ---- verilog/wdtit_top.sv ----
// watchdog / interval timer: registers, counter, overflow actions
// ------------------------------------------------------------
// Notes on behaviour
// - byte reads of control, counter and reset status at three addresses.
// - watchdog mode when mode select and count enable are both one.
// - watchdog overflow drives overflow_out_n low for 128 clocks.
// - with reset enable set, chip reset starts with the overflow output.
// - reset kind bit picks power-on or manual chip reset.
// - internal watchdog reset lasts 512 clocks.
// - external reset wins over a coincident overflow and clears the flag.
// - watchdog reset does not touch port, pin function or output-enable registers.
// - interval mode raises an interrupt request on every overflow.
// - standby refused while counting; software stops counting first.
// - on NMI in standby count at old rate, leave standby on wrap.
// - interval flag and interrupt request are set in the same cycle.
// - watchdog flag is set one clock before the overflow output goes low.
// - counter write in third bus state wins over a coincident tick.
// - without reset enable, overflow resets only counter and control register.
// - keyed word writes to counter and control share one address.
// - reset register keyed writes clear the flag or load enable and kind.
// - counter held at zero while count enable is clear, except during standby wake.
// - prescale select picks one of eight system clock divisions.
// ------------------------------------------------------------
`timescale 1ns/100ps
module wdtit_top (
	// clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RSTN,
	// cpu bus
	input wire logic [31:0] I_ADDR,
	input wire logic I_RD,
	input wire logic I_WR_WORD,
	input wire logic I_WR_T3,
	input wire logic [15:0] I_WDATA,
	output logic [7:0] O_RDATA,
	// standby control
	input wire logic I_STBY_REQ,
	input wire logic I_NMI,
	output logic O_STBY_ACTIVE,
	output logic O_STBY_REFUSED,
	output logic O_CLK_RUN,
	// overflow outputs
	output logic O_OVERFLOW_OUT_N,
	output logic O_INTERVAL_INTERRUPT,
	output logic O_CHIP_RST_PWRON,
	output logic O_CHIP_RST_MANUAL
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum {S_RUN, S_STBY, S_WAKE} wdtit_stby_t;
	wdtit_stby_t stby_q;
	logic [7:0] cnt_q;
	logic ovf_flag_q;
	logic mode_q;
	logic en_q;
	logic [2:0] psel_q;
	logic watchdog_overflow_flag_q;
	logic rst_ena_q;
	logic rst_kind_q;
	logic kind_latched_q;
	logic ovf_read_q;
	logic watchdog_overflow_flag_read_q;
	logic wrap;
	logic wd_ovf;
	logic it_ovf;
	logic wd_soft;
	logic ovf_pulse;
	logic crst_pulse;
	logic wr_cnt;
	logic wr_ctrl;
	logic wr_rst_data;
	logic wr_flag_clr;
	logic rd_ctrl;
	logic rd_rst;
	wdtit_tick_if tk ();

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	// keyed shared address
	assign wr_cnt = I_WR_WORD && I_ADDR == wdtit_pkg::ADDR_CNT_CTRL_WR
		&& I_WDATA[15:8] == wdtit_pkg::KEY_CNT;
	assign wr_ctrl = I_WR_WORD && I_ADDR == wdtit_pkg::ADDR_CNT_CTRL_WR
		&& I_WDATA[15:8] == wdtit_pkg::KEY_CTRL;
	assign wr_rst_data = I_WR_WORD && I_ADDR == wdtit_pkg::ADDR_RST_WR
		&& I_WDATA[15:8] == wdtit_pkg::KEY_RST_DATA;
	assign wr_flag_clr = I_WR_WORD && I_ADDR == wdtit_pkg::ADDR_RST_WR
		&& I_WDATA[15:8] == wdtit_pkg::KEY_FLAG_CLR && I_WDATA[7:0] == wdtit_pkg::FLAG_CLR_DATA;
	assign rd_ctrl = I_RD && I_ADDR == wdtit_pkg::ADDR_CTRL_RD;
	assign rd_rst = I_RD && I_ADDR == wdtit_pkg::ADDR_RST_RD;

	// ------------------------------------------------------------
	// prescaler and counter
	// ------------------------------------------------------------
	// standby wake counts at the setting held from before standby
	assign tk.run = en_q | (stby_q == S_WAKE);
	assign tk.sel = psel_q;

	wdtit_prescaler u_pre (
		.i_clk(I_SYS_CLK),
		.i_rstn(I_RSTN),
		.tk(tk)
	);

	assign wrap = tk.tick && cnt_q == 8'hff && !(wr_cnt && I_WR_T3);
	assign wd_ovf = wrap && en_q && mode_q;
	assign it_ovf = wrap && en_q && !mode_q;
	// local reset when chip reset is off
	assign wd_soft = wd_ovf && !rst_ena_q;

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cnt_q <= wdtit_pkg::CNT_RESET;
		end else if (wr_cnt && I_WR_T3) begin
			cnt_q <= I_WDATA[7:0];
		end else if (wd_soft || (!en_q && stby_q != S_WAKE)) begin
			cnt_q <= wdtit_pkg::CNT_RESET;
		end else if (tk.tick) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			mode_q <= 1'b0;
			en_q <= 1'b0;
			psel_q <= wdtit_pkg::PRESCALE_RESET;
		end else if (wd_soft) begin
			mode_q <= 1'b0;
			en_q <= 1'b0;
			psel_q <= wdtit_pkg::PRESCALE_RESET;
		end else if (wr_ctrl && I_WR_T3) begin
			mode_q <= I_WDATA[wdtit_pkg::CTRL_MODE_BIT];
			en_q <= I_WDATA[wdtit_pkg::CTRL_EN_BIT];
			psel_q <= I_WDATA[2:0];
		end
	end

	// flag clears on watchdog local reset, or by write only after it has been read as one; set wins over clear
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ovf_flag_q <= 1'b0;
			ovf_read_q <= 1'b0;
		end else if (wd_soft) begin
			ovf_flag_q <= 1'b0;
			ovf_read_q <= 1'b0;
		end else if (it_ovf) begin
			ovf_flag_q <= 1'b1;
		end else begin
			if (rd_ctrl && ovf_flag_q) begin
				ovf_read_q <= 1'b1;
			end
			if (wr_ctrl && I_WR_T3 && ovf_read_q && !I_WDATA[wdtit_pkg::CTRL_OVF_BIT]) begin
				ovf_flag_q <= 1'b0;
				ovf_read_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// reset control register
	// ------------------------------------------------------------
	// cleared by the external pin, or by a keyed flag-clear write once the flag has been read as one
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			watchdog_overflow_flag_q <= 1'b0;
			watchdog_overflow_flag_read_q <= 1'b0;
		end else if (wd_ovf) begin
			watchdog_overflow_flag_q <= 1'b1;
		end else begin
			if (rd_rst && watchdog_overflow_flag_q) begin
				watchdog_overflow_flag_read_q <= 1'b1;
			end
			if (wr_flag_clr && I_WR_T3 && watchdog_overflow_flag_read_q) begin
				watchdog_overflow_flag_q <= 1'b0;
				watchdog_overflow_flag_read_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rst_ena_q <= 1'b0;
			rst_kind_q <= 1'b0;
		end else if (stby_q == S_STBY) begin
			rst_ena_q <= 1'b0;
			rst_kind_q <= 1'b0;
		end else if (wr_rst_data && I_WR_T3) begin
			// data key loads bits 6 and 5
			rst_ena_q <= I_WDATA[wdtit_pkg::RST_ENA_BIT];
			rst_kind_q <= I_WDATA[wdtit_pkg::RST_KIND_BIT];
		end
	end

	// ------------------------------------------------------------
	// overflow output and chip reset
	// ------------------------------------------------------------
	// 128 clock pulse
	wdtit_pulse_timer #(
		.LEN(wdtit_pkg::OVF_OUT_CYCLES)
	) u_ovf_pulse (
		.i_clk(I_SYS_CLK),
		.i_rstn(I_RSTN),
		.i_start(wd_ovf),
		.o_active(ovf_pulse)
	);

	// chip reset starts with the overflow output
	wdtit_pulse_timer #(
		.LEN(wdtit_pkg::CHIP_RST_CYCLES)
	) u_rst_pulse (
		.i_clk(I_SYS_CLK),
		.i_rstn(I_RSTN),
		.i_start(wd_ovf && rst_ena_q),
		.o_active(crst_pulse)
	);

	// kind held for the whole reset, software may not retarget it midway
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			kind_latched_q <= 1'b0;
		end else if (wd_ovf) begin
			kind_latched_q <= rst_kind_q;
		end
	end

	// ------------------------------------------------------------
	// output pins
	// ------------------------------------------------------------
	// registered pin; shifts by the same clock as the chip reset, so both start together
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_OVERFLOW_OUT_N <= 1'b1;
		end else begin
			O_OVERFLOW_OUT_N <= !ovf_pulse;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_CHIP_RST_PWRON <= 1'b0;
			O_CHIP_RST_MANUAL <= 1'b0;
		end else begin
			O_CHIP_RST_PWRON <= crst_pulse && !kind_latched_q;
			O_CHIP_RST_MANUAL <= crst_pulse && kind_latched_q;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_INTERVAL_INTERRUPT <= 1'b0;
		end else begin
			O_INTERVAL_INTERRUPT <= it_ovf;
		end
	end

	// ------------------------------------------------------------
	// standby
	// ------------------------------------------------------------
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			stby_q <= S_RUN;
			O_STBY_REFUSED <= 1'b0;
		end else begin
			O_STBY_REFUSED <= 1'b0;
			unique case (stby_q)
				S_RUN: begin
					if (I_STBY_REQ && en_q) begin
						O_STBY_REFUSED <= 1'b1;
					end else if (I_STBY_REQ) begin
						stby_q <= S_STBY;
					end
				end
				S_STBY: begin
					if (I_NMI) begin
						stby_q <= S_WAKE;
					end
				end
				S_WAKE: begin
					if (tk.tick && cnt_q == 8'hff) begin
						stby_q <= S_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_STBY_ACTIVE <= 1'b0;
			O_CLK_RUN <= 1'b1;
		end else begin
			O_STBY_ACTIVE <= stby_q != S_RUN;
			O_CLK_RUN <= stby_q == S_RUN;
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	// three byte read addresses
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_RDATA <= 8'h00;
		end else if (rd_ctrl) begin
			O_RDATA <= {ovf_flag_q, mode_q, en_q, 5'h00} | wdtit_pkg::CTRL_RESERVED_ONES
				| {5'h00, psel_q};
		end else if (I_RD && I_ADDR == wdtit_pkg::ADDR_CNT_RD) begin
			O_RDATA <= cnt_q;
		end else if (rd_rst) begin
			O_RDATA <= {watchdog_overflow_flag_q, rst_ena_q, rst_kind_q, 5'h00} | wdtit_pkg::RST_RESERVED_ONES;
		end else begin
			O_RDATA <= 8'h00;
		end
	end
endmodule

// ---- inc/wdtit_pkg.sv ----
// shared constants for the watchdog / interval timer
package wdtit_pkg;
	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_CTRL_RD = 32'hffff8610;
	localparam logic [31:0] ADDR_CNT_RD = 32'hffff8611;
	localparam logic [31:0] ADDR_RST_RD = 32'hffff8613;
	localparam logic [31:0] ADDR_CNT_CTRL_WR = 32'hffff8610;
	localparam logic [31:0] ADDR_RST_WR = 32'hffff8612;
	// ------------------------------------------------------------
	// write keys
	// ------------------------------------------------------------
	localparam logic [7:0] KEY_CNT = 8'h5a;
	localparam logic [7:0] KEY_CTRL = 8'ha5;
	localparam logic [7:0] KEY_RST_DATA = 8'h5a;
	localparam logic [7:0] KEY_FLAG_CLR = 8'ha5;
	localparam logic [7:0] FLAG_CLR_DATA = 8'h00;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_OVF_BIT = 7;
	localparam int CTRL_MODE_BIT = 6;
	localparam int CTRL_EN_BIT = 5;
	localparam int RST_WATCHDOG_OVERFLOW_FLAG_BIT = 7;
	localparam int RST_ENA_BIT = 6;
	localparam int RST_KIND_BIT = 5;
	// ------------------------------------------------------------
	// reset values and read-as-one masks
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_RESERVED_ONES = 8'h18;
	localparam logic [7:0] RST_RESERVED_ONES = 8'h1f;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [2:0] PRESCALE_RESET = 3'h0;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int OVF_OUT_CYCLES = 128;
	localparam int CHIP_RST_CYCLES = 512;
	localparam int PRESCALE_WIDTH = 13;
	// prescaler tap for each select code: phi/2,64,128,256,512,1024,4096,8192
	localparam logic [3:0] TAP0 = 4'h0;
	localparam logic [3:0] TAP1 = 4'h5;
	localparam logic [3:0] TAP2 = 4'h6;
	localparam logic [3:0] TAP3 = 4'h7;
	localparam logic [3:0] TAP4 = 4'h8;
	localparam logic [3:0] TAP5 = 4'h9;
	localparam logic [3:0] TAP6 = 4'hb;
	localparam logic [3:0] TAP7 = 4'hc;
endpackage

// ---- inc/wdtit_tick_if.sv ----
// tick request and answer between the top and the prescaler
`timescale 1ns/100ps
interface wdtit_tick_if;
	logic run;
	logic [2:0] sel;
	logic tick;
	modport ctrl (output run, output sel, input tick);
	modport pre (input run, input sel, output tick);
endinterface

// ---- verilog/wdtit_prescaler.sv ----
// divider of the system clock, cleared while stopped, with selectable tick tap
`timescale 1ns/100ps
module wdtit_prescaler (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// tick port
	wdtit_tick_if.pre tk
);
	logic [wdtit_pkg::PRESCALE_WIDTH-1:0] div_q;
	logic [wdtit_pkg::PRESCALE_WIDTH-1:0] div_d;
	logic [3:0] tap;
	logic [wdtit_pkg::PRESCALE_WIDTH-1:0] ones;

	// divider cleared while stopped so each run starts from a fresh period
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	always_comb begin
		div_d = tk.run ? div_q + 1'b1 : '0;
	end

	always_comb begin
		unique case (tk.sel)
			3'h0: tap = wdtit_pkg::TAP0;
			3'h1: tap = wdtit_pkg::TAP1;
			3'h2: tap = wdtit_pkg::TAP2;
			3'h3: tap = wdtit_pkg::TAP3;
			3'h4: tap = wdtit_pkg::TAP4;
			3'h5: tap = wdtit_pkg::TAP5;
			3'h6: tap = wdtit_pkg::TAP6;
			3'h7: tap = wdtit_pkg::TAP7;
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < wdtit_pkg::PRESCALE_WIDTH; g++) begin : g_ones
			assign ones[g] = (g > int'(tap)) ? 1'b1 : div_q[g];
		end
	endgenerate

	// tick when every divider bit up to the tap is one, bits above it masked
	assign tk.tick = tk.run & (&ones);
endmodule

// ---- verilog/wdtit_pulse_timer.sv ----
// fixed-length active pulse started by a one-cycle trigger
`timescale 1ns/100ps
module wdtit_pulse_timer #(
	parameter int LEN = 128
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// trigger and pulse
	input wire logic i_start,
	output logic o_active
);
	localparam int CW = $clog2(LEN + 1);
	logic [CW-1:0] cnt_q;

	// retrigger restarts the full length
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
		end else if (i_start) begin
			cnt_q <= CW'(LEN);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_active <= 1'b0;
		end else begin
			o_active <= i_start | (cnt_q > CW'(1));
		end
	end
endmodule

// ---- verification/wdtit_monitor.sv ----
// assertion checker on the timer top ports
`timescale 1ns/100ps
module wdtit_monitor (
	// clock and reset
	input logic I_SYS_CLK,
	input logic I_RSTN,
	// watched ports
	input logic I_RD,
	input logic [7:0] O_RDATA,
	input logic O_STBY_ACTIVE,
	input logic O_STBY_REFUSED,
	input logic O_CLK_RUN,
	input logic O_OVERFLOW_OUT_N,
	input logic O_INTERVAL_INTERRUPT,
	input logic O_CHIP_RST_PWRON,
	input logic O_CHIP_RST_MANUAL
);
	logic rst_on;
	logic [7:0] lo_q;
	logic [9:0] rs_q;
	assign rst_on = O_CHIP_RST_PWRON | O_CHIP_RST_MANUAL;
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_RSTN);
	// cycles the overflow output has been low
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN)
			lo_q <= 8'h00;
		else
			lo_q <= O_OVERFLOW_OUT_N ? 8'h00 : lo_q + 8'h01;
	end
	// cycles the chip reset has been active
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN)
			rs_q <= 10'h000;
		else
			rs_q <= rst_on ? rs_q + 10'h001 : 10'h000;
	end
	// ----------------
	// checks
	// ----------------
	chk_ovf_short: assert property ($rose(O_OVERFLOW_OUT_N) |-> lo_q == 8'h80)
		else $error("overflow pulse ended early");
	chk_ovf_long: assert property (lo_q <= 8'h80)
		else $error("overflow pulse too long");
	chk_rst_short: assert property ($fell(rst_on) |-> rs_q == 10'h200)
		else $error("chip reset ended early");
	chk_rst_long: assert property (rs_q <= 10'h200)
		else $error("chip reset too long");
	chk_rst_with_ovf: assert property ($rose(rst_on) |-> $fell(O_OVERFLOW_OUT_N))
		else $error("chip reset not with overflow output");
	chk_rst_one_kind: assert property (!(O_CHIP_RST_PWRON && O_CHIP_RST_MANUAL))
		else $error("both reset kinds active");
	chk_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
		else $error("read data without read");
	chk_irq_pulse: assert property (O_INTERVAL_INTERRUPT |=> !O_INTERVAL_INTERRUPT)
		else $error("interrupt longer than one cycle");
	chk_refuse_pulse: assert property (O_STBY_REFUSED |-> !O_STBY_ACTIVE ##1 !O_STBY_REFUSED)
		else $error("refusal pulse wrong");
	chk_stby_clk: assert property ($rose(O_STBY_ACTIVE) |-> ##[0:1] !O_CLK_RUN)
		else $error("clocks still run in standby");
	cover property ($fell(O_OVERFLOW_OUT_N));
	cover property (O_INTERVAL_INTERRUPT);
	cover property ($rose(O_CHIP_RST_MANUAL));
	cover property (O_STBY_REFUSED);
endmodule

// ---- verification/wdtit_sys_model.sv ----
// system side: external reset circuit and interrupt sink
`timescale 1ns/100ps
module wdtit_sys_model (
	// clock
	input wire logic i_clk,
	// device outputs
	input wire logic i_ovf_n,
	input wire logic i_chip_rst,
	input wire logic i_irq,
	// measured figures
	output logic [15:0] o_ovf_len,
	output logic [15:0] o_rst_len,
	output logic [15:0] o_irq_cnt
);
	logic [15:0] lo_q = 16'h0000;
	logic [15:0] rs_q = 16'h0000;
	initial begin
		o_ovf_len = 16'h0000;
		o_rst_len = 16'h0000;
		o_irq_cnt = 16'h0000;
	end
	always @(posedge i_clk) begin
		lo_q <= i_ovf_n ? 16'h0000 : lo_q + 16'h0001;
		if (i_ovf_n && lo_q != 16'h0000)
			o_ovf_len <= lo_q;
	end
	always @(posedge i_clk) begin
		rs_q <= i_chip_rst ? rs_q + 16'h0001 : 16'h0000;
		if (!i_chip_rst && rs_q != 16'h0000)
			o_rst_len <= rs_q;
	end
	always @(posedge i_clk) begin
		if (i_irq)
			o_irq_cnt <= o_irq_cnt + 16'h0001;
	end
endmodule

// ---- verification/test_watchdog_interval_timer.sv ----
// self-checking bench for the watchdog / interval timer
`timescale 1ns/100ps
module test_watchdog_interval_timer;
	localparam logic [31:0] A_C = wdtit_pkg::ADDR_CTRL_RD;
	localparam logic [31:0] A_N = wdtit_pkg::ADDR_CNT_RD;
	localparam logic [31:0] A_R = wdtit_pkg::ADDR_RST_RD;
	localparam logic [31:0] A_W = wdtit_pkg::ADDR_CNT_CTRL_WR;
	localparam logic [31:0] A_X = wdtit_pkg::ADDR_RST_WR;
	localparam logic [7:0] K_C = wdtit_pkg::KEY_CTRL;
	localparam logic [7:0] K_N = wdtit_pkg::KEY_CNT;
	localparam logic [31:0] RA [4] = '{A_C, A_N, A_R, A_X};
	localparam logic [7:0] RE [4] = '{8'h18, 8'h00, 8'h1f, 8'h00};
	localparam logic [7:0] RS [3] = '{8'h60, 8'h40, 8'h00};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [31:0] addr = 32'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic t3 = 1'b0;
	logic [15:0] wdata = 16'h0;
	logic stby = 1'b0;
	logic nmi = 1'b0;
	logic [7:0] rdata;
	logic s_act, s_ref, clk_run, ovf_n, irq, r_pwr, r_man;
	logic [15:0] ovf_len, rst_len, irq_cnt;
	int bad_count = 0;
	int n_tests = 0;
	int n;
	logic [7:0] v;
	logic [7:0] e;
	always #20 clk = ~clk;
	wdtit_top u_dut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_RD(rd),
		.I_WR_WORD(wr), .I_WR_T3(t3), .I_WDATA(wdata), .O_RDATA(rdata),
		.I_STBY_REQ(stby), .I_NMI(nmi), .O_STBY_ACTIVE(s_act), .O_STBY_REFUSED(s_ref),
		.O_CLK_RUN(clk_run), .O_OVERFLOW_OUT_N(ovf_n), .O_INTERVAL_INTERRUPT(irq),
		.O_CHIP_RST_PWRON(r_pwr), .O_CHIP_RST_MANUAL(r_man));
	wdtit_sys_model u_sys (.i_clk(clk), .i_ovf_n(ovf_n), .i_chip_rst(r_pwr | r_man),
		.i_irq(irq), .o_ovf_len(ovf_len), .o_rst_len(rst_len), .o_irq_cnt(irq_cnt));
	// ----------------
	// tasks
	// ----------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	// word write: two wait states, commit in the third state
	task automatic wr16(input logic [31:0] a, input logic [7:0] k, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= {k, d};
		wr <= 1'b1;
		repeat (2) @(posedge clk);
		t3 <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		t3 <= 1'b0;
	endtask
	task automatic rd8(input logic [31:0] a, output logic [7:0] q);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic pls;
		@(posedge clk);
		stby <= 1'b1;
		@(posedge clk);
		stby <= 1'b0;
		#1;
	endtask
	function automatic logic ev(input int s);
		case (s)
			0: return irq;
			1: return !ovf_n;
			default: return clk_run;
		endcase
	endfunction
	// bounded wait; n holds the cycles taken
	task automatic wt(input int s, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (ev(s) !== 1'b1 && n < lim);
		if (n >= lim)
			chkv(16'h1, 16'h0);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------
	// tests
	// ----------------
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd8(RA[i], v);
			chk8(v, RE[i]);
		end
		for (int c = 0; c < 2; c++) begin
			wr16(A_W, K_C, 8'h38 | 8'(c));
			wt(0, 20000);
			wt(0, 20000);
			chkv(16'(n), 16'(256 * (c ? 64 : 2)));
			rd8(A_C, v);
			chk8(v, 8'hb8 | 8'(c));
			wr16(A_W, K_C, 8'h18 | 8'(c));
		end
		chkv(irq_cnt, 16'h4);
		wr16(A_W, K_C, 8'h3f);
		wr16(A_W, K_N, 8'h77);
		wr16(A_W, 8'h00, 8'h11);
		rd8(A_N, v);
		chk8(v, 8'h77);
		wr16(A_W, K_C, 8'h58);
		for (int k = 0; k < 3; k++) begin
			e = RS[k];
			wr16(A_X, wdtit_pkg::KEY_RST_DATA, e);
			wr16(A_W, K_C, 8'h78);
			wr16(A_W, K_N, 8'hf0);
			wt(1, 200);
			chkv({14'h0, r_man, r_pwr}, {14'h0, e[6] & e[5], e[6] & !e[5]});
			if (k == 2) begin
				rd8(A_C, v);
				chk8(v, 8'h18);
			end
			wr16(A_W, K_C, 8'h58);
			repeat (600) @(posedge clk);
			chkv(ovf_len, 16'h80);
			if (e[6])
				chkv(rst_len, 16'h200);
			rd8(A_R, v);
			chk8(v, e | 8'h9f);
			wr16(A_X, wdtit_pkg::KEY_FLAG_CLR, wdtit_pkg::FLAG_CLR_DATA);
			rd8(A_R, v);
			chk8(v, e | 8'h1f);
		end
		wr16(A_W, K_C, 8'h38);
		pls();
		chkv({14'h0, s_ref, s_act}, 16'h2);
		wr16(A_W, K_C, 8'h18);
		pls();
		// standby pins follow the state register one clock later
		@(posedge clk);
		#1 chkv({14'h0, s_act, clk_run}, 16'h2);
		repeat (20) @(posedge clk);
		#1 chkv({15'h0, clk_run}, 16'h0);
		@(posedge clk);
		nmi <= 1'b1;
		wt(2, 2000);
		chkv(16'(n >= 508 && n <= 520), 16'h1);
		nmi <= 1'b0;
		wr16(A_X, wdtit_pkg::KEY_RST_DATA, 8'h40);
		wr16(A_W, K_C, 8'h58);
		wr16(A_W, K_C, 8'h78);
		wt(1, 1000);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1 chkv({14'h0, ovf_n, r_pwr}, 16'h2);
		rd8(A_R, v);
		chk8(v, 8'h1f);
		final_report();
	end
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		final_report();
	end
endmodule
bind wdtit_top wdtit_monitor u_mon (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_RD(I_RD),
	.O_RDATA(O_RDATA), .O_STBY_ACTIVE(O_STBY_ACTIVE), .O_STBY_REFUSED(O_STBY_REFUSED),
	.O_CLK_RUN(O_CLK_RUN), .O_OVERFLOW_OUT_N(O_OVERFLOW_OUT_N),
	.O_INTERVAL_INTERRUPT(O_INTERVAL_INTERRUPT), .O_CHIP_RST_PWRON(O_CHIP_RST_PWRON),
	.O_CHIP_RST_MANUAL(O_CHIP_RST_MANUAL));
